// [hdl/tail_pkg.sv]
// Shared constants for the tail-symbol register bank and its loader
package tail_pkg;
  localparam int TAIL_COUNT = 6;
  localparam int SHARED_USED = 3;
  localparam int SYM_W = 6;
  localparam int SYMS_PER_FIELD = 3;
  localparam int FIELD_W = SYM_W * SYMS_PER_FIELD;
  localparam int IDX_W = 3;
  localparam int DATA_W = 32;
  localparam logic [FIELD_W-1:0] FIELD_RESET = 18'h00000;
  localparam logic [SYM_W-1:0] TERM_STATE = 6'h00;
  // Link indices of the six tail words
  localparam logic [IDX_W-1:0] IDX_FIRST_SYS = 3'h0;
  localparam logic [IDX_W-1:0] IDX_FIRST_PAR_A = 3'h1;
  localparam logic [IDX_W-1:0] IDX_FIRST_PAR_B = 3'h2;
  localparam logic [IDX_W-1:0] IDX_SECOND_SYS = 3'h3;
  localparam logic [IDX_W-1:0] IDX_SECOND_PAR_A = 3'h4;
  localparam logic [IDX_W-1:0] IDX_SECOND_PAR_B = 3'h5;
  // Loader registers on AHB-Lite (byte addresses)
  localparam logic [7:0] OFS_SYM_A = 8'h00;
  localparam logic [7:0] OFS_SYM_B = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam int CTRL_LOAD_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_RIDX_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RDONE_BIT = 2;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [2:0] {
    RATE_1_5 = 3'h0,
    RATE_1_4 = 3'h1,
    RATE_1_3 = 3'h2,
    RATE_1_2 = 3'h3,
    RATE_3_4 = 3'h4
  } code_rate_t;
endpackage

// [hdl/tail_cfg_if.sv]
// Configuration link between the loader and the tail register bank
`timescale 1ns/100ps
`default_nettype none
interface tail_cfg_if;
  import tail_pkg::*;
  logic req;
  logic write;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport dev (input req, input write, input idx, input wdata, output ack, output rdata);
  modport host (output req, output write, output idx, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// [hdl/tail_regs_dev.sv]
// Tail-symbol register bank of the turbo decoder, fed over the configuration link
`timescale 1ns/100ps
`default_nettype none
module tail_regs_dev
  import tail_pkg::*;
#(
  parameter int NUM_TAILS = TAIL_COUNT
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration link
  tail_cfg_if.dev cfg,
  // Decoder side
  input wire logic shared_mode,
  input wire logic decode_start,
  output logic [NUM_TAILS-1:0][SYMS_PER_FIELD-1:0][SYM_W-1:0] tail_sym_ff,
  output logic [NUM_TAILS-1:0] tail_active_ff,
  output logic tails_loaded_ff,
  output logic decode_go_ff,
  output logic decode_refused_ff,
  output logic [SYM_W-1:0] term_state_ff
);

  initial begin
    if (NUM_TAILS != TAIL_COUNT) begin
      $error("tail_regs_dev: NUM_TAILS must equal the fixed bank size");
    end
  end

  // Storage
  logic [NUM_TAILS-1:0][FIELD_W-1:0] field_ff;
  logic [NUM_TAILS-1:0] written_ff;
  logic ack_ff;
  logic [DATA_W-1:0] rdata_ff;

  // Link decode
  wire take = cfg.req && !ack_ff;
  wire idx_ok = (int'(cfg.idx) < NUM_TAILS);
  wire take_wr = take && cfg.write && idx_ok;
  wire [FIELD_W-1:0] wr_field = cfg.wdata[FIELD_W-1:0];
  wire [DATA_W-1:0] rd_word = idx_ok ? {{(DATA_W-FIELD_W){1'b0}}, field_ff[cfg.idx]} : '0;
  wire all_written = &written_ff;

  // Shared mode drops the upper three words from the decoder's view
  function automatic logic used_in_mode(input int n, input logic shared);
    return !shared || (n < SHARED_USED);
  endfunction

  // Symbol k of a field sits at bits k*6 +: 6
  function automatic logic [SYM_W-1:0] sym_of(input logic [FIELD_W-1:0] f, input int k);
    return f[k*SYM_W +: SYM_W];
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= take;
      if (take && !cfg.write) begin
        rdata_ff <= rd_word;
      end
    end
  end

  assign cfg.ack = ack_ff;
  assign cfg.rdata = rdata_ff;

  genvar n, k;
  generate
    for (n = 0; n < NUM_TAILS; n++) begin : g_tail
      wire hit = take_wr && (int'(cfg.idx) == n);
      wire used = used_in_mode(n, shared_mode);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          field_ff[n] <= FIELD_RESET;
          written_ff[n] <= 1'b0;
          tail_active_ff[n] <= 1'b0;
        end else begin
          if (hit) begin
            field_ff[n] <= wr_field;
            written_ff[n] <= 1'b1;
          end
          tail_active_ff[n] <= used;
        end
      end
      for (k = 0; k < SYMS_PER_FIELD; k++) begin : g_sym
        // Unused words read as zero symbols so the decoder cannot pick up stale tails
        wire [SYM_W-1:0] sym = used ? sym_of(field_ff[n], k) : '0;
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            tail_sym_ff[n][k] <= '0;
          end else begin
            tail_sym_ff[n][k] <= sym;
          end
        end
      end
    end
  endgenerate

  // Decode launch gated on a complete load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tails_loaded_ff <= 1'b0;
      decode_go_ff <= 1'b0;
      decode_refused_ff <= 1'b0;
      term_state_ff <= TERM_STATE;
    end else begin
      tails_loaded_ff <= all_written;
      decode_go_ff <= decode_start && all_written;
      decode_refused_ff <= decode_start && !all_written;
      term_state_ff <= TERM_STATE;
    end
  end

endmodule
`default_nettype wire

// [hdl/tail_dma_host.sv]
// Loader that builds the six tail words from rate and symbols and writes them over the link
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tail_dma_host
  import tail_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hwdata,
  output logic hreadyout,
  output logic [DATA_W-1:0] hrdata,
  output logic hresp,
  // Configuration link
  tail_cfg_if.host cfg
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_DROP = 2'b10
  } host_state_t;

  host_state_t state_ff, nxt_state;
  logic [FIELD_W-1:0] sym_a_ff, sym_b_ff;
  logic [2:0] rate_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [DATA_W-1:0] hrdata_ff;
  logic busy_ff, done_ff, rdone_ff, loading_ff;
  logic [IDX_W-1:0] idx_ff;
  logic req_ff, write_ff;
  logic [DATA_W-1:0] wdata_ff, rword_ff;

  // Field built from one symbol, optionally zeroing the upper two positions or the whole field
  function automatic logic [FIELD_W-1:0] spread(input logic [SYM_W-1:0] s, input logic only0, input logic none);
    if (none) begin
      return '0;
    end
    return only0 ? {{(FIELD_W-SYM_W){1'b0}}, s} : {s, s, s};
  endfunction

  wire addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
  wire wr_now = wr_pend_ff;
  wire ctrl_wr = wr_now && (wr_addr_ff == OFS_CTRL) && !busy_ff;
  wire start_load = ctrl_wr && hwdata[CTRL_LOAD_BIT];
  wire start_read = ctrl_wr && !hwdata[CTRL_LOAD_BIT] && hwdata[CTRL_READ_BIT];
  // Word is built from the index that the request will carry, so wdata and idx launch together
  wire step_idx = (state_ff == ST_DROP) && loading_ff && (idx_ff != IDX_SECOND_PAR_B);
  wire [IDX_W-1:0] nxt_idx = start_load ? IDX_FIRST_SYS :
    start_read ? hwdata[CTRL_RIDX_LSB +: IDX_W] :
    step_idx ? idx_ff + 3'h1 : idx_ff;
  wire is_34 = (rate_ff == RATE_3_4);
  wire low_rate = (rate_ff == RATE_1_5) || (rate_ff == RATE_1_4);

  // Word for each link index, following the rate-dependent fill patterns
  logic [FIELD_W-1:0] word_sel;
  always_comb begin
    unique case (nxt_idx)
      IDX_FIRST_SYS: word_sel = spread(sym_a_ff[5:0], 1'b0, 1'b0);
      IDX_FIRST_PAR_A: word_sel = spread(sym_a_ff[11:6], is_34, 1'b0);
      IDX_FIRST_PAR_B: word_sel = spread(sym_a_ff[17:12], 1'b0, !low_rate);
      IDX_SECOND_SYS: word_sel = spread(sym_b_ff[5:0], 1'b0, 1'b0);
      IDX_SECOND_PAR_A: word_sel = spread(sym_b_ff[11:6], is_34, 1'b0);
      default: word_sel = spread(sym_b_ff[17:12], 1'b0, !low_rate);
    endcase
  end

  wire [DATA_W-1:0] status_word = {29'h0, rdone_ff, done_ff, busy_ff};
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    unique case (haddr)
      OFS_SYM_A: rd_mux = {14'h0, sym_a_ff};
      OFS_SYM_B: rd_mux = {14'h0, sym_b_ff};
      OFS_RATE: rd_mux = {29'h0, rate_ff};
      OFS_STATUS: rd_mux = status_word;
      OFS_RDATA: rd_mux = rword_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire last_idx = (idx_ff == IDX_SECOND_PAR_B);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start_load || start_read) nxt_state = ST_REQ;
      ST_REQ: if (cfg.ack) nxt_state = ST_DROP;
      ST_DROP: nxt_state = (loading_ff && !last_idx) ? ST_REQ : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= '0;
      sym_a_ff <= FIELD_RESET;
      sym_b_ff <= FIELD_RESET;
      rate_ff <= RATE_RESET;
    end else begin
      wr_pend_ff <= addr_ph && hwrite;
      wr_addr_ff <= haddr;
      hrdata_ff <= (addr_ph && !hwrite) ? rd_mux : 32'h00000000;
      if (wr_now && wr_addr_ff == OFS_SYM_A) sym_a_ff <= hwdata[FIELD_W-1:0];
      if (wr_now && wr_addr_ff == OFS_SYM_B) sym_b_ff <= hwdata[FIELD_W-1:0];
      if (wr_now && wr_addr_ff == OFS_RATE) rate_ff <= hwdata[2:0];
    end
  end

  // Link sequencer: all six words go out before done rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rdone_ff <= 1'b0;
      loading_ff <= 1'b0;
      idx_ff <= '0;
      req_ff <= 1'b0;
      write_ff <= 1'b0;
      wdata_ff <= '0;
      rword_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (start_load) begin
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
        loading_ff <= 1'b1;
      end else if (start_read) begin
        busy_ff <= 1'b1;
        rdone_ff <= 1'b0;
        loading_ff <= 1'b0;
      end
      idx_ff <= nxt_idx;
      req_ff <= (nxt_state == ST_REQ);
      write_ff <= loading_ff || start_load;
      wdata_ff <= {14'h0, word_sel};
      if (state_ff == ST_REQ && cfg.ack && !loading_ff) rword_ff <= cfg.rdata;
      if (state_ff == ST_DROP && !(loading_ff && !last_idx)) begin
        busy_ff <= 1'b0;
        loading_ff <= 1'b0;
        if (loading_ff) done_ff <= 1'b1;
        else rdone_ff <= 1'b1;
      end
    end
  end

  assign cfg.req = req_ff;
  assign cfg.write = write_ff;
  assign cfg.idx = idx_ff;
  assign cfg.wdata = wdata_ff;
  assign hreadyout = 1'b1;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

endmodule
`default_nettype wire

// [testbench/tail_link_sva.sv]
// Protocol checks on the link between the loader and the tail bank
`timescale 1ns/100ps
`default_nettype none
module tail_link_sva
  import tail_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration link
  input wire logic req,
  input wire logic write,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [DATA_W-1:0] rdata
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_take;
    req && !ack;
  endsequence
  // Out-of-range read is still answered, with an empty word
  sequence s_bad_read;
    req && !ack && !write && idx > 3'h5 ##1 ack;
  endsequence
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack held too long");
  a_ack_prompt: assert property (s_take |=> ack) else $error("ack late");
  a_req_held: assert property (s_take |=> req && $stable(idx) && $stable(wdata) && $stable(write))
    else $error("request changed before ack");
  a_ack_has_req: assert property (ack |-> req) else $error("ack without request");
  a_req_drops: assert property (ack |=> !req) else $error("request not dropped");
  a_rdata_upper_zero: assert property (rdata[DATA_W-1:FIELD_W] == '0) else $error("rdata upper set");
  a_rdata_on_read: assert property ($changed(rdata) |-> ack && !write) else $error("rdata moved");
  a_bad_read_zero: assert property (s_bad_read |-> rdata == '0) else $error("bad index data");
endmodule
`default_nettype wire

// [testbench/turbo_tail_symbol_regs_tb.sv]
// Self-checking bench: loader over AHB-Lite feeding the tail bank
`timescale 1ns/100ps
`default_nettype none
module turbo_tail_symbol_regs_tb;
  import tail_pkg::*;
  logic hclk, hresetn, hsel, hwrite, shared_mode, decode_start, hreadyout, hresp, loaded, go, refused;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [5:0][2:0][5:0] sym;
  logic [5:0] act, term;
  logic [35:0] cur;
  logic [2:0] cur_rate;
  int fails = 0;
  int checks_done = 0;
  tail_cfg_if cfg_bus();
  tail_dma_host tail_dma_host_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cfg(cfg_bus));
  tail_regs_dev tail_regs_dev_i(.hclk(hclk), .hresetn(hresetn), .cfg(cfg_bus), .shared_mode(shared_mode),
    .decode_start(decode_start), .tail_sym_ff(sym), .tail_active_ff(act), .tails_loaded_ff(loaded),
    .decode_go_ff(go), .decode_refused_ff(refused), .term_state_ff(term));
  tail_link_sva tail_link_sva_i(.hclk(hclk), .hresetn(hresetn), .req(cfg_bus.req), .write(cfg_bus.write),
    .idx(cfg_bus.idx), .wdata(cfg_bus.wdata), .ack(cfg_bus.ack), .rdata(cfg_bus.rdata));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run();
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Entered just after an edge; zero-wait slave still honoured through hready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask
  task wait_stat(input int b);
    do ahb(1'b0, OFS_STATUS, 32'h0, rd); while (rd[STAT_BUSY_BIT] !== 1'b0 || rd[b] !== 1'b1);
  endtask
  function automatic logic [17:0] exp_word(input int n, input logic [2:0] r, input logic [35:0] s);
    logic [5:0] v;
    v = s[n*6 +: 6];
    if (n % 3 == 1 && r == RATE_3_4) return {12'h0, v};
    if (n % 3 == 2 && r > RATE_1_4) return 18'h0;
    return {v, v, v};
  endfunction
  task pulse_decode(input logic exp_go);
    decode_start <= 1'b1;
    @(posedge hclk);
    decode_start <= 1'b0;
    @(posedge hclk);
    chk({31'h0, go}, {31'h0, exp_go});
    chk({31'h0, refused}, {31'h0, ~exp_go});
  endtask
  task t_reset();
    for (int n = 0; n < 6; n++) chk({14'h0, sym[n]}, 32'h0);
    chk({26'h0, term}, {26'h0, TERM_STATE});
    chk({31'h0, loaded}, 32'h0);
    ahb(1'b0, OFS_RDATA, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
  endtask
  // Upper garbage on the symbol words must never reach the field
  task t_load(input logic [2:0] r, input logic [35:0] s);
    cur = s;
    cur_rate = r;
    wr(OFS_SYM_A, {14'h3FFF, s[17:0]});
    wr(OFS_SYM_B, {14'h3FFF, s[35:18]});
    wr(OFS_RATE, {29'h0, r});
    wr(OFS_CTRL, 32'h1);
    wait_stat(STAT_DONE_BIT);
    for (int n = 0; n < 6; n++) chk({14'h0, sym[n]}, {14'h0, exp_word(n, r, s)});
    chk({26'h0, act}, 32'h3F);
    chk({31'h0, loaded}, 32'h1);
  endtask
  task t_readback();
    for (int n = 0; n < 7; n++) begin
      wr(OFS_CTRL, 32'h2 | (n << CTRL_RIDX_LSB));
      wait_stat(STAT_RDONE_BIT);
      ahb(1'b0, OFS_RDATA, 32'h0, rd);
      chk(rd, n < 6 ? {14'h0, exp_word(n, cur_rate, cur)} : 32'h0);
    end
  endtask
  task t_shared();
    shared_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int n = 0; n < 6; n++) chk({14'h0, sym[n]}, n < 3 ? {14'h0, exp_word(n, cur_rate, cur)} : 32'h0);
    chk({26'h0, act}, 32'h07);
    shared_mode <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({14'h0, sym[4]}, {14'h0, exp_word(4, cur_rate, cur)});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    shared_mode = 1'b0;
    decode_start = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    pulse_decode(1'b0);
    for (int r = 0; r < 5; r++) t_load(3'(r), 36'hA5C39E1D7 ^ {6{6'(r * 11)}});
    t_readback();
    t_shared();
    pulse_decode(1'b1);
    complete_run();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
